// ===== hdl/partition_hot_reset_sequencer.sv
// partition hot reset and upstream secondary bus reset sequencer
// What this block does
// - hot reset from TS1, DL_Down, or control bit
// - upstream LTSSM to Hot Reset or Detect
// - linked-up downstream ports send hot-reset TS1
// - partition logic returned to initial state
// - disabled downstream link goes to Detect instead
// - non-sticky fields reset, sticky fields kept
// - stay in reset while trigger persists
// - after trigger clears, ports retrain, resume
// - disable bit blocks DL_Down hot reset
// - disabled: no LTSSM move, no reset steps
// - disabled link-down: peer-to-peer still forwarded
// - disabled link-down: non-downstream TLPs unsupported
// - disabled link-down: root-bound generated TLPs dropped
// - disabled link-down: downstream ASPM independent of upstream
// - disable bit never blocks TS1 hot reset
// - secondary bus reset starts on written one
// - first step: linked-up downstream ports send TS1
// - hold downstream idle until bit cleared
// - secondary-side TLPs unsupported during bus reset
`timescale 1ns/1ps
`include "hot_reset_defs.svh"
module partition_hot_reset_sequencer
    import hot_reset_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [3:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [3:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic US_HOT_RESET_TS1_IN,
    input wire logic US_DL_DOWN_IN,
    input wire logic [`NUM_DS-1:0] DS_LINK_UP_IN,
    input wire logic [`NUM_DS-1:0] DS_LINK_DISABLED_IN,
    output logic US_LTSSM_HOT_RESET_OUT,
    output logic US_LTSSM_DETECT_OUT,
    output logic [`NUM_DS-1:0] DS_SEND_HOT_RESET_TS1_OUT,
    output logic [`NUM_DS-1:0] DS_LTSSM_DETECT_OUT,
    output logic PARTITION_RESET_OUT,
    output logic DS_RESET_OUT,
    output logic LINK_TRAIN_OUT,
    output logic P2P_FORWARD_OUT,
    output logic NON_DS_TLP_UR_OUT,
    output logic DROP_ROOT_BOUND_OUT,
    output logic DS_ASPM_INDEPENDENT_OUT,
    output logic SEC_TLP_UR_OUT
);
    // ****************************************
    // pin input synchronisers
    // ****************************************
    logic [2*`NUM_DS+1:0] pin_sync;
    logic ts1_s, dl_down_s;
    logic [`NUM_DS-1:0] ds_up_s, ds_dis_s;
    sync2 #(.WIDTH(2*`NUM_DS+2)) u_sync (
        .clk_in(SYS_CLK_IN),
        .reset_n_in(RESET_N_IN),
        .d_in({US_HOT_RESET_TS1_IN, US_DL_DOWN_IN, DS_LINK_UP_IN, DS_LINK_DISABLED_IN}),
        .q_out(pin_sync)
    );
    assign {ts1_s, dl_down_s, ds_up_s, ds_dis_s} = pin_sync;

    // ****************************************
    // register bus
    // ****************************************
    // link_down_hot_reset_disable and the sticky word survive hot reset
    logic ldhrd_r, ldhrd_nxt, swrst_r, swrst_nxt, sbr_r, sbr_nxt;
    logic [31:0] sticky_r, sticky_nxt, w_data_r, w_data_nxt, rdata_r, rdata_nxt;
    logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt;
    logic rvalid_r, rvalid_nxt, arready_r, arready_nxt;
    logic [3:0] aw_addr_r, aw_addr_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    seq_state_type state_r, state_nxt;
    logic part_rst;
    logic [31:0] status_word;

    always_comb begin
        ldhrd_nxt = ldhrd_r;
        swrst_nxt = swrst_r;
        sbr_nxt = sbr_r;
        sticky_nxt = sticky_r;
        aw_ok_nxt = aw_ok_r;
        aw_addr_nxt = aw_addr_r;
        w_ok_nxt = w_ok_r;
        w_data_nxt = w_data_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        arready_nxt = 1'b0;
        if (S_AXI_AWVALID_IN && !aw_ok_r && !bvalid_r) begin
            aw_ok_nxt = 1'b1;
            aw_addr_nxt = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && !w_ok_r && !bvalid_r) begin
            w_ok_nxt = 1'b1;
            w_data_nxt = S_AXI_WDATA_IN;
        end
        if (aw_ok_r && w_ok_r) begin
            aw_ok_nxt = 1'b0;
            w_ok_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `OKAY;
            case (aw_addr_r)
                `ADDR_CTRL: begin
                    ldhrd_nxt = w_data_r[`CTRL_LDHRD_BIT];
                    swrst_nxt = w_data_r[`CTRL_SWRST_BIT];
                end
                // write of one starts bus reset
                `ADDR_BRIDGE_CTRL: sbr_nxt = w_data_r[`BRIDGE_SEC_RESET_BIT];
                `ADDR_STAT: bresp_nxt = `OKAY;
                `ADDR_STICKY: sticky_nxt = w_data_r;
                default: bresp_nxt = `SLVERR;
            endcase
        end
        if (bvalid_r && S_AXI_BREADY_IN) begin
            bvalid_nxt = 1'b0;
        end
        if (S_AXI_ARVALID_IN && !arready_r && !rvalid_r) begin
            arready_nxt = 1'b1;
            rvalid_nxt = 1'b1;
            rresp_nxt = `OKAY;
            case (S_AXI_ARADDR_IN)
                `ADDR_CTRL: rdata_nxt = {30'h0, swrst_r, ldhrd_r};
                `ADDR_BRIDGE_CTRL: rdata_nxt = 32'(sbr_r) << `BRIDGE_SEC_RESET_BIT;
                `ADDR_STAT: rdata_nxt = status_word;
                `ADDR_STICKY: rdata_nxt = sticky_r;
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `SLVERR;
                end
            endcase
        end
        if (rvalid_r && S_AXI_RREADY_IN) begin
            rvalid_nxt = 1'b0;
        end
        // non-sticky state back to reset value
        if (part_rst) begin
            swrst_nxt = 1'b0;
            sbr_nxt = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ldhrd_r <= 1'b0;
            swrst_r <= 1'b0;
            sbr_r <= 1'b0;
            sticky_r <= 32'h0;
            aw_ok_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_ok_r <= 1'b0;
            w_data_r <= 32'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0;
            arready_r <= 1'b0;
        end else begin
            ldhrd_r <= ldhrd_nxt;
            swrst_r <= swrst_nxt;
            sbr_r <= sbr_nxt;
            sticky_r <= sticky_nxt;
            aw_ok_r <= aw_ok_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_ok_r <= w_ok_nxt;
            w_data_r <= w_data_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign S_AXI_AWREADY_OUT = aw_ok_r;
    assign S_AXI_WREADY_OUT = w_ok_r;
    assign S_AXI_BVALID_OUT = bvalid_r;
    assign S_AXI_BRESP_OUT = bresp_r;
    assign S_AXI_ARREADY_OUT = arready_r;
    assign S_AXI_RVALID_OUT = rvalid_r;
    assign S_AXI_RRESP_OUT = rresp_r;
    assign S_AXI_RDATA_OUT = rdata_r;

    // ****************************************
    // reset sequencer
    // ****************************************
    logic dl_trig, trig;
    logic by_ts1_r, by_ts1_nxt, us_hr_r, us_hr_nxt, us_det_r, us_det_nxt;
    logic prst_r, prst_nxt, dsrst_r, dsrst_nxt, train_r, train_nxt;
    logic lddis_r, lddis_nxt, sec_ur_r, sec_ur_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [`NUM_DS-1:0] ds_ts1_r, ds_ts1_nxt, ds_det_r, ds_det_nxt;

    // disable bit masks only the DL_Down path
    assign dl_trig = dl_down_s && !ldhrd_r;
    // any of three sources; ts1 never masked
    assign trig = ts1_s || dl_trig || swrst_r;
    assign part_rst = prst_r;
    assign status_word = {24'h0, lddis_r, train_r, dsrst_r, prst_r, 1'b0, state_r};

    always_comb begin
        state_nxt = state_r;
        by_ts1_nxt = by_ts1_r;
        cnt_nxt = cnt_r;
        ds_ts1_nxt = '0;
        ds_det_nxt = '0;
        us_hr_nxt = 1'b0;
        us_det_nxt = 1'b0;
        prst_nxt = 1'b0;
        dsrst_nxt = 1'b0;
        train_nxt = 1'b0;
        case (state_r)
            ST_RUN: begin
                if (trig) begin
                    state_nxt = ST_HOT;
                    by_ts1_nxt = ts1_s;
                end else if (sbr_r) begin
                    state_nxt = ST_SBR;
                end
            end
            ST_HOT, ST_HOLD: begin
                // Hot Reset for ts1 trigger, else Detect
                us_hr_nxt = by_ts1_r;
                us_det_nxt = !by_ts1_r;
                ds_ts1_nxt = ds_up_s & ~ds_dis_s;
                // disabled links go to Detect instead
                ds_det_nxt = ds_dis_s;
                prst_nxt = 1'b1;
                state_nxt = ST_HOLD;
                if (!trig) begin
                    state_nxt = ST_TRAIN;
                    cnt_nxt = 3'(`SETTLE_CYC);
                end
            end
            ST_TRAIN: begin
                train_nxt = 1'b1;
                cnt_nxt = cnt_r - 3'h1;
                if (cnt_r == 3'h1) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_SBR: begin
                // first step: hot reset on linked-up ports
                ds_ts1_nxt = ds_up_s & ~ds_dis_s;
                ds_det_nxt = ds_dis_s;
                dsrst_nxt = 1'b1;
                state_nxt = ST_SBR_HOLD;
            end
            ST_SBR_HOLD: begin
                // idle until software clears the bit
                dsrst_nxt = 1'b1;
                ds_ts1_nxt = ds_up_s & ~ds_dis_s;
                if (trig) begin
                    state_nxt = ST_HOT;
                    by_ts1_nxt = ts1_s;
                end else if (!sbr_r) begin
                    state_nxt = ST_TRAIN;
                    cnt_nxt = 3'(`SETTLE_CYC);
                end
            end
            default: state_nxt = ST_RUN;
        endcase
        // link-down with reset disabled: no reset steps
        lddis_nxt = dl_down_s && ldhrd_r;
        // secondary side unsupported during bus reset
        sec_ur_nxt = sbr_r || dsrst_nxt;
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r <= ST_RUN;
            by_ts1_r <= 1'b0;
            cnt_r <= 3'h0;
            ds_ts1_r <= '0;
            ds_det_r <= '0;
            us_hr_r <= 1'b0;
            us_det_r <= 1'b0;
            prst_r <= 1'b0;
            dsrst_r <= 1'b0;
            train_r <= 1'b0;
            lddis_r <= 1'b0;
            sec_ur_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            by_ts1_r <= by_ts1_nxt;
            cnt_r <= cnt_nxt;
            ds_ts1_r <= ds_ts1_nxt;
            ds_det_r <= ds_det_nxt;
            us_hr_r <= us_hr_nxt;
            us_det_r <= us_det_nxt;
            prst_r <= prst_nxt;
            dsrst_r <= dsrst_nxt;
            train_r <= train_nxt;
            lddis_r <= lddis_nxt;
            sec_ur_r <= sec_ur_nxt;
        end
    end

    assign US_LTSSM_HOT_RESET_OUT = us_hr_r;
    assign US_LTSSM_DETECT_OUT = us_det_r;
    assign DS_SEND_HOT_RESET_TS1_OUT = ds_ts1_r;
    assign DS_LTSSM_DETECT_OUT = ds_det_r;
    assign PARTITION_RESET_OUT = prst_r;
    assign DS_RESET_OUT = dsrst_r;
    assign LINK_TRAIN_OUT = train_r;
    // peer-to-peer keeps flowing when upstream absent
    assign P2P_FORWARD_OUT = lddis_r;
    assign NON_DS_TLP_UR_OUT = lddis_r;
    assign DROP_ROOT_BOUND_OUT = lddis_r;
    assign DS_ASPM_INDEPENDENT_OUT = lddis_r;
    assign SEC_TLP_UR_OUT = sec_ur_r;
endmodule : partition_hot_reset_sequencer

// ===== hdl/hot_reset_defs.svh
// constants for the partition hot reset sequencer
`ifndef HOT_RESET_DEFS_SVH
`define HOT_RESET_DEFS_SVH
`define NUM_DS 4
`define ADDR_CTRL 4'h0
`define ADDR_BRIDGE_CTRL 4'h4
`define ADDR_STAT 4'h8
`define ADDR_STICKY 4'hC
`define CTRL_LDHRD_BIT 0
`define CTRL_SWRST_BIT 1
`define BRIDGE_SEC_RESET_BIT 6
`define OKAY 2'h0
`define SLVERR 2'h2
`define SETTLE_NS 20
`define SETTLE_CYC (((`SETTLE_NS) + 4) / 5)
`endif

// ===== hdl/hot_reset_pkg.sv
// types for the partition hot reset sequencer
package hot_reset_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_HOT = 3'h1,
        ST_HOLD = 3'h2,
        ST_TRAIN = 3'h3,
        ST_SBR = 3'h4,
        ST_SBR_HOLD = 3'h5
    } seq_state_type;
endpackage : hot_reset_pkg

// ===== hdl/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end
    assign q_out = q_r;
endmodule : sync2

// ===== sim/hot_reset_props.sv
// concurrent checks on the partition hot reset sequencer ports
`timescale 1ns/1ps
`include "hot_reset_defs.svh"
module hot_reset_props (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic US_HOT_RESET_TS1_IN,
    input wire logic US_LTSSM_HOT_RESET_OUT,
    input wire logic US_LTSSM_DETECT_OUT,
    input wire logic [`NUM_DS-1:0] DS_SEND_HOT_RESET_TS1_OUT,
    input wire logic [`NUM_DS-1:0] DS_LTSSM_DETECT_OUT,
    input wire logic PARTITION_RESET_OUT,
    input wire logic DS_RESET_OUT,
    input wire logic LINK_TRAIN_OUT,
    input wire logic P2P_FORWARD_OUT,
    input wire logic NON_DS_TLP_UR_OUT,
    input wire logic DROP_ROOT_BOUND_OUT,
    input wire logic DS_ASPM_INDEPENDENT_OUT,
    input wire logic SEC_TLP_UR_OUT
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    a_ltssm_one_target: assert property (!(US_LTSSM_HOT_RESET_OUT && US_LTSSM_DETECT_OUT))
        else $error("both upstream ltssm targets");
    a_ltssm_in_reset: assert property ((US_LTSSM_HOT_RESET_OUT || US_LTSSM_DETECT_OUT) |-> PARTITION_RESET_OUT)
        else $error("ltssm move outside reset");
    a_send_or_detect: assert property ((DS_SEND_HOT_RESET_TS1_OUT & DS_LTSSM_DETECT_OUT) == '0)
        else $error("port both sends and detects");
    a_ts1_in_reset: assert property (|DS_SEND_HOT_RESET_TS1_OUT |-> (PARTITION_RESET_OUT || DS_RESET_OUT))
        else $error("hot reset ts1 outside reset");
    a_hold_on_ts1: assert property (US_HOT_RESET_TS1_IN [*6] |-> PARTITION_RESET_OUT)
        else $error("partition left reset with trigger");
    a_train_follows: assert property ($fell(PARTITION_RESET_OUT) |-> ##[0:2] LINK_TRAIN_OUT)
        else $error("no training after reset");
    a_train_ends: assert property ($rose(LINK_TRAIN_OUT) |-> ##[1:8] !LINK_TRAIN_OUT)
        else $error("training window stuck");
    a_mode_flags_agree: assert property (P2P_FORWARD_OUT == NON_DS_TLP_UR_OUT
        && P2P_FORWARD_OUT == DROP_ROOT_BOUND_OUT && P2P_FORWARD_OUT == DS_ASPM_INDEPENDENT_OUT)
        else $error("link-down mode flags differ");
    a_sec_ur_in_sbr: assert property (DS_RESET_OUT |-> SEC_TLP_UR_OUT)
        else $error("secondary tlps accepted in bus reset");
endmodule : hot_reset_props

// ===== sim/hot_reset_link_model.sv
// far side: upstream root port and downstream components
`timescale 1ns/1ps
module hot_reset_link_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ts1_cmd_in,
    input wire logic dl_down_cmd_in,
    input wire logic [3:0] up_cmd_in,
    input wire logic [3:0] dis_cmd_in,
    output logic us_ts1_out,
    output logic us_dl_down_out,
    output logic [3:0] ds_up_out,
    output logic [3:0] ds_dis_out
);
    // ****************
    // link state
    // ****************
    // a disabled link is never up, so disabled wins over up
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            us_ts1_out <= 1'b0;
            us_dl_down_out <= 1'b0;
            ds_up_out <= 4'h0;
            ds_dis_out <= 4'h0;
        end else begin
            us_ts1_out <= ts1_cmd_in;
            us_dl_down_out <= dl_down_cmd_in;
            ds_up_out <= up_cmd_in & ~dis_cmd_in;
            ds_dis_out <= dis_cmd_in;
        end
    end
endmodule : hot_reset_link_model

// ===== sim/tb_partition_hot_reset_sequencer.sv
// self-checking bench for the partition hot reset sequencer
`timescale 1ns/1ps
`include "hot_reset_defs.svh"
module tb_partition_hot_reset_sequencer;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic ts1 = 1'b0, dld = 1'b0, pt, pd;
    logic [3:0] awa = 4'h0, ara = 4'h0, up = 4'h0, dis = 4'h0, pu, pdis, upm, dism, dss, dsd;
    logic [31:0] wd = 32'h0, rd, rdat, sticky;
    logic [1:0] rr, br, rresp;
    logic awr, wr, bv, arr, rv, ush, usd, prst, dsr, trn, p2p, nur, drp, asp, sur;
    int mismatches = 0, n_checks = 0, cyc = 0;
    hot_reset_link_model link_u (.clk_in(clk), .reset_n_in(rst_n), .ts1_cmd_in(ts1),
        .dl_down_cmd_in(dld), .up_cmd_in(up), .dis_cmd_in(dis), .us_ts1_out(pt),
        .us_dl_down_out(pd), .ds_up_out(pu), .ds_dis_out(pdis));
    partition_hot_reset_sequencer dut_u (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr),
        .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rre), .US_HOT_RESET_TS1_IN(pt), .US_DL_DOWN_IN(pd),
        .DS_LINK_UP_IN(pu), .DS_LINK_DISABLED_IN(pdis), .US_LTSSM_HOT_RESET_OUT(ush),
        .US_LTSSM_DETECT_OUT(usd), .DS_SEND_HOT_RESET_TS1_OUT(dss), .DS_LTSSM_DETECT_OUT(dsd),
        .PARTITION_RESET_OUT(prst), .DS_RESET_OUT(dsr), .LINK_TRAIN_OUT(trn),
        .P2P_FORWARD_OUT(p2p), .NON_DS_TLP_UR_OUT(nur), .DROP_ROOT_BOUND_OUT(drp),
        .DS_ASPM_INDEPENDENT_OUT(asp), .SEC_TLP_UR_OUT(sur));
    // ****************
    // shared tasks
    // ****************
    task report_and_stop;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    // an edge passes first so no strobe is driven twice in one step
    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        bre <= 1'b0;
        chk(br, `OKAY);
    endtask : axw
    task axr(input logic [3:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        rd = rdat;
        rr = rresp;
    endtask : axr
    function automatic logic pick(input int sel);
        return (sel == 0) ? prst : (sel == 1) ? trn : dsr;
    endfunction : pick
    // bounded wait for a level, then compare it
    task wait_sig(input int sel, input logic v);
        for (int i = 0; i < 40 && pick(sel) !== v; i++) @(posedge clk);
        @(posedge clk);
        chk(pick(sel), v);
    endtask : wait_sig
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // ****************
    // scenarios
    // ****************
    initial begin
        void'($urandom(32'hB8A5CE4A));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        axr(`ADDR_BRIDGE_CTRL);
        chk(rd, 32'h0);
        axr(4'h2);
        chk(rr, `SLVERR);
        for (int k = 0; k < 3; k++) begin
            sticky = $urandom();
            upm = 4'($urandom());
            dism = 4'($urandom()) & ~upm;
            axw(`ADDR_STICKY, sticky);
            axw(`ADDR_CTRL, 32'h1);
            up <= upm;
            dis <= dism;
            ts1 <= 1'b1;
            wait_sig(0, 1'b1);
            chk({ush, usd}, 2'b10);
            chk(dss, upm);
            chk(dsd, dism);
            repeat (12) @(posedge clk);
            chk(prst, 1'b1);
            ts1 <= 1'b0;
            wait_sig(1, 1'b1);
            wait_sig(1, 1'b0);
            chk(prst, 1'b0);
            axr(`ADDR_STICKY);
            chk(rd, sticky);
            axr(`ADDR_CTRL);
            chk(rd, 32'h1);
        end
        dld <= 1'b1;
        repeat (12) @(posedge clk);
        chk(prst, 1'b0);
        chk({p2p, nur, drp, asp}, 4'hF);
        axr(`ADDR_STAT);
        chk(rd[7:4], 4'h8);
        axw(`ADDR_CTRL, 32'h0);
        wait_sig(0, 1'b1);
        chk({ush, usd}, 2'b01);
        chk({p2p, nur, drp, asp}, 4'h0);
        dld <= 1'b0;
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        axw(`ADDR_CTRL, 32'h2);
        wait_sig(0, 1'b1);
        chk({ush, usd}, 2'b01);
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        axw(`ADDR_BRIDGE_CTRL, 32'h1 << `BRIDGE_SEC_RESET_BIT);
        wait_sig(2, 1'b1);
        chk(dss, upm & ~dism);
        chk(sur, 1'b1);
        repeat (20) @(posedge clk);
        chk(dsr, 1'b1);
        axw(`ADDR_BRIDGE_CTRL, 32'h0);
        wait_sig(2, 1'b0);
        @(posedge clk);
        chk(sur, 1'b0);
        report_and_stop();
    end
endmodule : tb_partition_hot_reset_sequencer
bind partition_hot_reset_sequencer hot_reset_props props_u (.SYS_CLK_IN(SYS_CLK_IN),
    .RESET_N_IN(RESET_N_IN), .US_HOT_RESET_TS1_IN(US_HOT_RESET_TS1_IN),
    .US_LTSSM_HOT_RESET_OUT(US_LTSSM_HOT_RESET_OUT), .US_LTSSM_DETECT_OUT(US_LTSSM_DETECT_OUT),
    .DS_SEND_HOT_RESET_TS1_OUT(DS_SEND_HOT_RESET_TS1_OUT),
    .DS_LTSSM_DETECT_OUT(DS_LTSSM_DETECT_OUT), .PARTITION_RESET_OUT(PARTITION_RESET_OUT),
    .DS_RESET_OUT(DS_RESET_OUT), .LINK_TRAIN_OUT(LINK_TRAIN_OUT),
    .P2P_FORWARD_OUT(P2P_FORWARD_OUT), .NON_DS_TLP_UR_OUT(NON_DS_TLP_UR_OUT),
    .DROP_ROOT_BOUND_OUT(DROP_ROOT_BOUND_OUT), .DS_ASPM_INDEPENDENT_OUT(DS_ASPM_INDEPENDENT_OUT),
    .SEC_TLP_UR_OUT(SEC_TLP_UR_OUT));
